// ==== hw/gcr_device.sv ====
`timescale 1ns/1ps
// ==========================================================
// Overview of operation
// [R1] selected clear acts exactly like device clear
// [R2] clear empties buffers, aborts, goes idle
// [R3] system controller holds interface clear 100 ms
// [R4] interface clear stops transfers, drops addressing
// [R5] interface clear keeps interface and service request
// [R6] interface clear keeps all enables and filters
// [R7] interface clear keeps queues and trigger setup
// [R8] only the system controller drives interface clear
// [R9] system controller is active after reset
// [R10] controller addresses talker before take control
// [R11] take control moves active role to receiver
// [R12] system controller mode makes device active, indicated
// [R13] take control accepted only while addressed talker
// [R14] return address stored, limited 0 to 30
// [R15] optional second argument is secondary address
// [R16] default return address is 0
// [R17] controller should set return address first
// [R18] program pause, finish or reset returns control
// [R19] interface clear drops control immediately
// [R20] idle 10 s without task returns control
// [R21] finished controller task returns control
// [R22] active role held while controller task runs
// [R23] return: address talker, send take control
module gcr_device #(
    parameter longint IDLE_CYCLES = gcr_pkg::IDLE_CYCLES
) (
    input wire logic clk,
    input wire logic rst,
    gcr_bus_if.dev bus,
    input wire logic sys_ctrl_cfg,
    input wire logic pcb_valid,
    input wire logic [4:0] pcb_primary,
    input wire logic pcb_has_second,
    input wire logic [4:0] pcb_secondary,
    input wire logic my_addr_talk,
    input wire logic prog_running,
    input wire logic prog_stop,
    input wire logic task_busy,
    input wire logic task_done,
    output logic active_ctrl,
    output logic active_ind,
    output logic talker,
    output logic listener,
    output logic dev_clear,
    output logic [4:0] ret_primary,
    output logic [4:0] ret_secondary,
    output logic ret_has_second
);
    typedef enum logic [2:0] {ST_IDLE, ST_ACTIVE, ST_SEND_UNL, ST_SEND_TALK,
        ST_SEND_SEC, ST_SEND_TCT} gcr_state_t;

    // ==========================================================
    // input synchronisers
    logic ifc_s1_r, ifc_r, cv_s1_r, cv_r, cv_d_r;
    logic [7:0] cd_s1_r, cd_r;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ifc_s1_r <= 1'b0;
            ifc_r <= 1'b0;
            cv_s1_r <= 1'b0;
            cv_r <= 1'b0;
            cv_d_r <= 1'b0;
            cd_s1_r <= 8'h00;
            cd_r <= 8'h00;
        end else begin
            ifc_s1_r <= bus.ifc;
            ifc_r <= ifc_s1_r;
            cv_s1_r <= bus.cmd_valid;
            cv_r <= cv_s1_r;
            cv_d_r <= cv_r;
            cd_s1_r <= bus.cmd_data;
            cd_r <= cd_s1_r;
        end
    end
    wire cmd_stb = cv_r && !cv_d_r;
    wire tct_seen = cmd_stb && cd_r == gcr_pkg::CMD_TAKE_CTRL;

    // ==========================================================
    // clear handling: selected clear while addressed equals universal clear
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            dev_clear <= 1'b0;
        end else begin
            dev_clear <= cmd_stb && (cd_r == gcr_pkg::CMD_DEV_CLEAR ||
                (cd_r == gcr_pkg::CMD_SEL_CLEAR && listener)); // [R1] [R2]
        end
    end

    // ==========================================================
    // addressing; interface clear drops addressing here and, while sys_ctrl_cfg is low, also sends the controller role to ST_IDLE
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            talker <= 1'b0;
            listener <= 1'b0;
        end else if (ifc_r) begin
            talker <= 1'b0; // [R4] [R5] [R6] [R7]
            listener <= 1'b0;
        end else if (cmd_stb) begin
            if (cd_r == gcr_pkg::CMD_UNTALK) talker <= 1'b0;
            if (cd_r == gcr_pkg::CMD_UNLISTEN) listener <= 1'b0;
            if (cd_r[7:5] == 3'b010 && cd_r != gcr_pkg::CMD_UNTALK) begin
                talker <= my_addr_talk; // [R10]
            end
            if (cd_r[7:5] == 3'b001 && cd_r != gcr_pkg::CMD_UNLISTEN) begin
                listener <= my_addr_talk; // [R1]
            end
        end
    end

    // ==========================================================
    // return address store
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ret_primary <= gcr_pkg::RETURN_DEFAULT; // [R16]
            ret_secondary <= 5'h00;
            ret_has_second <= 1'b0;
        end else if (pcb_valid && pcb_primary <= gcr_pkg::ADDR_MAX) begin // [R14] [R17]
            ret_primary <= pcb_primary;
            ret_secondary <= pcb_secondary;
            ret_has_second <= pcb_has_second; // [R15]
        end
    end

    // ==========================================================
    // controller role
    gcr_state_t state_r;
    logic [gcr_pkg::CNT_W-1:0] idle_cnt_r;
    logic [7:0] tx_data_r;
    logic tx_valid_r;
    wire tx_go = !tx_valid_r;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_r <= ST_IDLE;
            tx_valid_r <= 1'b0;
            tx_data_r <= 8'h00;
        end else if (tx_valid_r) begin
            if (bus.dev_cmd_ready) tx_valid_r <= 1'b0;
        end else if (ifc_r && !sys_ctrl_cfg) begin
            state_r <= ST_IDLE; // [R19]
        end else begin
            case (state_r)
                ST_IDLE: begin
                    if (sys_ctrl_cfg) state_r <= ST_ACTIVE; // [R9] [R12] [R8]
                    else if (tct_seen && talker) state_r <= ST_ACTIVE; // [R13] [R11]
                end
                ST_ACTIVE: begin
                    if (!sys_ctrl_cfg && !task_busy) begin // [R22]
                        if ((prog_running && prog_stop) || (!prog_running &&
                            (task_done || idle_cnt_r >= gcr_pkg::CNT_W'(IDLE_CYCLES - 1))))
                            state_r <= ST_SEND_UNL; // [R18] [R20] [R21]
                    end
                end
                ST_SEND_UNL: begin
                    tx_data_r <= gcr_pkg::CMD_UNTALK;
                    tx_valid_r <= 1'b1;
                    state_r <= ST_SEND_TALK;
                end
                ST_SEND_TALK: begin
                    tx_data_r <= gcr_pkg::TALK_BASE | {3'b000, ret_primary}; // [R23]
                    tx_valid_r <= 1'b1;
                    state_r <= ret_has_second ? ST_SEND_SEC : ST_SEND_TCT;
                end
                ST_SEND_SEC: begin
                    tx_data_r <= gcr_pkg::SECOND_BASE | {3'b000, ret_secondary};
                    tx_valid_r <= 1'b1;
                    state_r <= ST_SEND_TCT;
                end
                ST_SEND_TCT: begin
                    tx_data_r <= gcr_pkg::CMD_TAKE_CTRL; // [R23]
                    tx_valid_r <= 1'b1;
                    state_r <= ST_IDLE;
                end
                default: state_r <= ST_IDLE;
            endcase
        end
    end
    assign bus.dev_cmd_data = tx_data_r;
    assign bus.dev_cmd_valid = tx_valid_r;

    // ==========================================================
    // idle timer, restarted by any controller task
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            idle_cnt_r <= '0;
        end else if (state_r != ST_ACTIVE || task_busy || prog_running) begin
            idle_cnt_r <= '0;
        end else if (tx_go) begin
            idle_cnt_r <= idle_cnt_r + 1'b1; // [R20]
        end
    end

    // ==========================================================
    // role outputs
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            active_ctrl <= 1'b0;
            active_ind <= 1'b0;
        end else begin
            active_ctrl <= state_r != ST_IDLE; // [R11]
            active_ind <= state_r != ST_IDLE; // [R12]
        end
    end
endmodule

// ==== hw/gcr_pkg.sv ====
package gcr_pkg;
    // ==========================================================
    // bus command bytes (ATN true)
    localparam logic [7:0] CMD_TAKE_CTRL = 8'h09;
    localparam logic [7:0] CMD_SEL_CLEAR = 8'h04;
    localparam logic [7:0] CMD_DEV_CLEAR = 8'h14;
    localparam logic [7:0] CMD_UNTALK = 8'h5f;
    localparam logic [7:0] CMD_UNLISTEN = 8'h3f;
    localparam logic [7:0] TALK_BASE = 8'h40;
    localparam logic [7:0] LISTEN_BASE = 8'h20;
    localparam logic [7:0] SECOND_BASE = 8'h60;
    localparam logic [4:0] ADDR_MAX = 5'h1e;
    localparam logic [4:0] RETURN_DEFAULT = 5'h00;
    // ==========================================================
    // timing
    localparam int CLK_MHZ = 250;
    localparam int IFC_TIME_MS = 100;
    localparam int IDLE_TIME_S = 10;
    localparam longint IFC_CYCLES = longint'(IFC_TIME_MS) * CLK_MHZ * 1000;
    localparam longint IDLE_CYCLES = longint'(IDLE_TIME_S) * CLK_MHZ * 1000000;
    localparam int CNT_W = 32;
endpackage

// ==== hw/gcr_bus_if.sv ====
`timescale 1ns/1ps
interface gcr_bus_if;
    logic [7:0] cmd_data;
    logic cmd_valid;
    logic ifc;
    logic [7:0] dev_cmd_data;
    logic dev_cmd_valid;
    logic dev_cmd_ready;
    modport dev (
        input cmd_data, cmd_valid, ifc, dev_cmd_ready,
        output dev_cmd_data, dev_cmd_valid
    );
    modport ctl (
        output cmd_data, cmd_valid, ifc, dev_cmd_ready,
        input dev_cmd_data, dev_cmd_valid
    );
endinterface

// ==== hw/gcr_controller.sv ====
`timescale 1ns/1ps
// far-end controller: passes control and pulses interface clear
module gcr_controller #(
    parameter longint IFC_CYCLES = gcr_pkg::IFC_CYCLES
) (
    input wire logic clk,
    input wire logic rst,
    gcr_bus_if.ctl bus,
    input wire logic is_sys_ctrl,
    input wire logic ifc_req,
    input wire logic [7:0] cmd_in,
    input wire logic cmd_in_valid,
    output logic cmd_in_ready,
    output logic [7:0] seen_data,
    output logic seen_valid
);
    logic [gcr_pkg::CNT_W-1:0] ifc_cnt_r;
    logic ifc_r, cv_r;
    logic [7:0] cd_r;
    // ==========================================================
    // interface clear pulse, system controller only
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ifc_r <= 1'b0;
            ifc_cnt_r <= '0;
        end else if (ifc_r) begin
            if (ifc_cnt_r >= gcr_pkg::CNT_W'(IFC_CYCLES - 1)) ifc_r <= 1'b0; // [R3]
            ifc_cnt_r <= ifc_cnt_r + 1'b1;
        end else if (ifc_req && is_sys_ctrl) begin // [R8]
            ifc_r <= 1'b1;
            ifc_cnt_r <= '0;
        end
    end
    // ==========================================================
    // command bytes: caller sends talk address before take control [R10] [R17]
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cv_r <= 1'b0;
            cd_r <= 8'h00;
            cmd_in_ready <= 1'b0;
        end else begin
            cmd_in_ready <= !cv_r && !cmd_in_ready;
            if (cmd_in_valid && cmd_in_ready) begin
                cd_r <= cmd_in;
                cv_r <= 1'b1;
            end else begin
                cv_r <= 1'b0;
            end
        end
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            seen_data <= 8'h00;
            seen_valid <= 1'b0;
        end else begin
            seen_valid <= bus.dev_cmd_valid;
            seen_data <= bus.dev_cmd_data; // [R11]
        end
    end
    assign bus.ifc = ifc_r;
    assign bus.cmd_data = cd_r;
    assign bus.cmd_valid = cv_r;
    assign bus.dev_cmd_ready = 1'b1;
endmodule

// ==== tb/gcr_properties.sv ====
`timescale 1ns/1ps
module gcr_properties #(
    parameter longint IFC_CYCLES = gcr_pkg::IFC_CYCLES
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] cmd_data,
    input wire logic cmd_valid,
    input wire logic ifc,
    input wire logic [7:0] dev_cmd_data,
    input wire logic dev_cmd_valid,
    input wire logic dev_cmd_ready
);
    // ==========================================================
    // helper: length of the current interface clear
    logic [31:0] ifc_len_r;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) ifc_len_r <= '0;
        else ifc_len_r <= ifc ? ifc_len_r + 32'h1 : '0;
    end
    // ==========================================================
    // properties
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    sequence s_dev(logic [7:0] v);
        dev_cmd_valid && dev_cmd_data == v;
    endsequence
    sequence s_talk;
        dev_cmd_valid && dev_cmd_data[7:5] == 3'b010 && dev_cmd_data != gcr_pkg::CMD_UNTALK;
    endsequence
    sequence s_second;
        dev_cmd_valid && dev_cmd_data[7:5] == 3'b011;
    endsequence
    a_ifc_hold_time: assert property ($fell(ifc) && !$past(rst) |-> ifc_len_r >= IFC_CYCLES)
        else $error("interface clear released early");
    a_cmd_spacing: assert property (cmd_valid |=> !cmd_valid [*2])
        else $error("command bytes too close");
    a_dev_byte_pulse: assert property (dev_cmd_valid |=> !dev_cmd_valid)
        else $error("device byte not a single cycle");
    a_untalk_then_talk: assert property (s_dev(gcr_pkg::CMD_UNTALK) |-> ##2 s_talk)
        else $error("untalk not followed by talk address");
    a_talk_then_next: assert property (s_talk |-> ##2 (s_second or s_dev(gcr_pkg::CMD_TAKE_CTRL)))
        else $error("talk address not followed by take control");
    a_second_then_take: assert property (s_second |-> ##2 s_dev(gcr_pkg::CMD_TAKE_CTRL))
        else $error("secondary address not followed by take control");
    a_take_after_addr: assert property (s_dev(gcr_pkg::CMD_TAKE_CTRL) |-> $past(dev_cmd_data[7:6], 2) == 2'b01)
        else $error("take control without addressing");
    a_ifc_silences_dev: assert property (ifc [*4] |-> !dev_cmd_valid)
        else $error("device sends during interface clear");
endmodule

// ==== tb/testbench.sv ====
`timescale 1ns/1ps
module testbench;
    logic clk = 0, rst = 1, cfg = 0, pv = 0, p2 = 0, talk = 0, run = 0, stop = 0;
    logic busy = 0, done = 0, sysc = 0, ifq = 0, civ = 0;
    logic [4:0] pp = 0, ps = 0, rp, rs;
    logic [7:0] ci = 0, sd;
    logic act, ind, tkr, lsn, dclr, hs, rdy, sv;
    logic [7:0] q[$];
    int err_total = 0, n_tests = 0, nclr = 0;
    gcr_bus_if bus();
    gcr_device #(.IDLE_CYCLES(50)) i_gcr_device(.clk(clk), .rst(rst), .bus(bus),
        .sys_ctrl_cfg(cfg), .pcb_valid(pv), .pcb_primary(pp), .pcb_has_second(p2),
        .pcb_secondary(ps), .my_addr_talk(talk), .prog_running(run), .prog_stop(stop),
        .task_busy(busy), .task_done(done), .active_ctrl(act), .active_ind(ind),
        .talker(tkr), .listener(lsn), .dev_clear(dclr), .ret_primary(rp),
        .ret_secondary(rs), .ret_has_second(hs));
    gcr_controller #(.IFC_CYCLES(20)) i_gcr_controller(.clk(clk), .rst(rst), .bus(bus),
        .is_sys_ctrl(sysc), .ifc_req(ifq), .cmd_in(ci), .cmd_in_valid(civ),
        .cmd_in_ready(rdy), .seen_data(sd), .seen_valid(sv));
    gcr_properties #(.IFC_CYCLES(20)) i_gcr_properties(.clk(clk), .rst(rst),
        .cmd_data(bus.cmd_data), .cmd_valid(bus.cmd_valid), .ifc(bus.ifc),
        .dev_cmd_data(bus.dev_cmd_data), .dev_cmd_valid(bus.dev_cmd_valid),
        .dev_cmd_ready(bus.dev_cmd_ready));
    initial begin
        forever #2 clk = ~clk;
    end
    always @(posedge clk) begin
        if (sv === 1'b1) q.push_back(sd);
        if (dclr === 1'b1) nclr++;
    end
    // ==========================================================
    // tasks
    task automatic chk(input logic [7:0] s, input logic [7:0] e);
        n_tests++;
        if (s !== e) begin
            err_total++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task automatic give_verdict();
        $display("tests=%0d errors=%0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic send(input logic [7:0] b, input logic t);
        int k;
        @(posedge clk);
        talk <= t;
        ci <= b;
        civ <= 1;
        for (k = 0; k < 50; k++) begin
            @(posedge clk);
            if (rdy === 1'b1) break;
        end
        civ <= 0;
        if (k == 50) err_total++;
        if (k == 50) give_verdict();
        cyc(8);
    endtask
    task automatic wact(input logic v, input int lim);
        int k;
        for (k = 0; k < lim && act !== v; k++) @(posedge clk);
        chk(8'(k < lim), 8'h1);
        if (k == lim) give_verdict();
    endtask
    task automatic take();
        q.delete();
        send(gcr_pkg::TALK_BASE | 8'h07, 1);
        send(gcr_pkg::CMD_TAKE_CTRL, 1);
        talk <= 0;
        wact(1, 20);
    endtask
    // one-cycle strobe: 0 return address, 1 task done, 2 program stop, 3 clear request
    task automatic pulse(input logic [1:0] w);
        @(posedge clk);
        {pv, done, stop, ifq} <= 4'h8 >> w;
        @(posedge clk);
        {pv, done, stop, ifq} <= 4'h0;
    endtask
    task automatic chkret(input logic [4:0] p, input logic [4:0] s, input logic two);
        cyc(12);
        chk(8'(q.size()), two ? 8'h4 : 8'h3);
        chk(q[0], gcr_pkg::CMD_UNTALK);
        chk(q[1], gcr_pkg::TALK_BASE | 8'(p));
        if (two) chk(q[2], gcr_pkg::SECOND_BASE | 8'(s));
        chk(q[q.size() - 1], gcr_pkg::CMD_TAKE_CTRL);
    endtask
    // ==========================================================
    // scenarios
    initial begin
        cyc(3);
        rst <= 0;
        cyc(3);
        chk(8'(act), 8'h0);
        chk(8'(rp), 8'(gcr_pkg::RETURN_DEFAULT));
        send(gcr_pkg::CMD_TAKE_CTRL, 0);
        cyc(4);
        chk(8'(act), 8'h0);
        take();
        cyc(30);
        chk(8'(act), 8'h1);
        wact(0, 60);
        chkret(5'h00, 5'h00, 0);
        pp <= 5'h1f;
        pulse(2'h0);
        cyc(3);
        chk(8'(rp), 8'h00);
        pp <= 5'h1e;
        ps <= 5'h05;
        p2 <= 1;
        pulse(2'h0);
        cyc(3);
        chk(8'({rp, hs}), 8'h3d);
        chk(8'(rs), 8'h05);
        busy <= 1;
        take();
        cyc(80);
        chk(8'(act), 8'h1);
        busy <= 0;
        pulse(2'h1);
        wact(0, 20);
        chkret(5'h1e, 5'h05, 1);
        run <= 1;
        take();
        pulse(2'h2);
        wact(0, 20);
        run <= 0;
        take();
        sysc <= 1;
        pulse(2'h3);
        wact(0, 8);
        chk(8'(tkr), 8'h0);
        chk(8'(rp), 8'h1e);
        cyc(30);
        sysc <= 0;
        pulse(2'h3);
        cyc(3);
        chk(8'(bus.ifc), 8'h0);
        send(gcr_pkg::CMD_SEL_CLEAR, 0);
        chk(8'(nclr), 8'h0);
        send(gcr_pkg::CMD_DEV_CLEAR, 0);
        chk(8'(nclr), 8'h1);
        send(gcr_pkg::LISTEN_BASE | 8'h07, 1);
        chk(8'(lsn), 8'h1);
        send(gcr_pkg::CMD_SEL_CLEAR, 1);
        chk(8'(nclr), 8'h2);
        cfg <= 1;
        cyc(8);
        chk(8'({act, ind}), 8'h3);
        rst <= 1;
        cyc(3);
        chk(8'(act), 8'h0);
        rst <= 0;
        cyc(3);
        chk(8'(act), 8'h1);
        give_verdict();
    end
endmodule
